// >>> verilog/clock_gen_pkg.sv
// Behaviour
// - Reset enters self-clocked mode, oscillator free-running.
// - Off mode holds main clock static on stop.
// - Internal-engaged mode multiplies the internal reference.
// - Unlocked engaged state keeps adjusting until lock.
// - Bypassed mode drives clock from external source.
// - External-engaged mode multiplies the external reference.
// - External first write reserves reference pin by select.
// - Oscillator output pin used only after external write.
// - High-gain bit selects higher amplitude oscillator.
// - Post divider offers eight divisors /1 to /128.
// - Loop output limited to 8 to 40 MHz.
// - Reference or lock loss requests reset or interrupt.
// - Oscillator setting kept across stop.
// - Oscillator holds frequency when reference is lost.
// - Loop output engages automatically after lock.
// - Non-running clock sources cannot be selected, except external-engaged from an engaged mode.
// - Status reports lock, lock loss, reference validity.
// - Internal 243 kHz reference takes software trim.
// - Half-rate 12.5 MHz reference clocks the debug controller.
// - Separate self-clocked source for periodic interrupt.
// - Fixed-frequency enable output beside other clocks.
// - Two oscillator ranges, 32 kHz and 16 MHz.
// - Range sets loop prescale to 64 or 1.
// - Internal first write blocks later external modes.
// - Bypass waits for valid external clock status.
// - Gain, range, reference select are write-once.
package clock_gen_pkg;
   localparam int CLK_KHZ         = 25000;
   localparam int IREF_KHZ        = 243;
   localparam int IREF_CYC        = CLK_KHZ / IREF_KHZ;
   localparam int IREF_BASE       = IREF_CYC - 32;
   localparam int DEBUG_KHZ       = 8000;
   localparam int DEBUG_HALF_CYC  = (CLK_KHZ / (2 * DEBUG_KHZ) < 1) ? 1 : CLK_KHZ / (2 * DEBUG_KHZ);
   localparam int DCO_MIN_MHZ     = 8;
   localparam int DCO_MAX_MHZ     = 40;
   localparam int DCO_SCALE       = 5;
   localparam logic [15:0] DCO_MIN   = 16'((DCO_MIN_MHZ * 65536) / (CLK_KHZ / 1000 * DCO_SCALE));
   localparam logic [15:0] DCO_MAX   = 16'((DCO_MAX_MHZ * 65536) / (CLK_KHZ / 1000 * DCO_SCALE));
   localparam logic [15:0] DCO_RESET = 16'h2000;
   localparam logic [7:0]  TRIM_RESET = 8'h80;
   localparam logic [5:0]  PRESCALE_LOW  = 6'd63;
   localparam logic [5:0]  PRESCALE_HIGH = 6'd0;
   localparam logic [15:0] MULT_UNIT     = 16'h0004;
   localparam logic [15:0] LOCK_TOL      = 16'h0001;
   localparam logic [15:0] UNLOCK_TOL    = 16'h0004;
   localparam logic [2:0]  LOCK_WINDOWS  = 3'h4;
   localparam logic [2:0] ADDR_CTRL1  = 3'h0;
   localparam logic [2:0] ADDR_CTRL2  = 3'h1;
   localparam logic [2:0] ADDR_STATUS = 3'h2;
   localparam logic [2:0] ADDR_DCO_HI = 3'h3;
   localparam logic [2:0] ADDR_DCO_LO = 3'h4;
   localparam logic [2:0] ADDR_TRIM   = 3'h5;
   localparam int C1_HGO     = 7;
   localparam int C1_RANGE   = 6;
   localparam int C1_EXT_REFERENCE_SELECT    = 5;
   localparam int C1_CLOCK_MODE_SELECT_HI = 4;
   localparam int C1_CLOCK_MODE_SELECT_LO = 3;
   localparam int C1_LOCD    = 1;
   localparam int C2_LOLRE   = 7;
   localparam int C2_MULT_LO = 4;
   localparam int C2_LOCRE   = 3;
   localparam int C2_DIV_LO  = 0;
   localparam int ST_LOSS_CLOCK = 2;
   localparam int ST_LOCKED     = 3;
   localparam int ST_EXT_VALID  = 4;
   localparam int ST_LOSS_LOCK  = 5;
   localparam logic [1:0] CLOCK_MODE_SELECT_SELF    = 2'h0;
   localparam logic [1:0] CLOCK_MODE_SELECT_ENG_INT = 2'h1;
   localparam logic [1:0] CLOCK_MODE_SELECT_BYPASS  = 2'h2;
   localparam logic [1:0] CLOCK_MODE_SELECT_ENG_EXT = 2'h3;
   typedef enum logic [2:0] {
      MODE_OFF, MODE_SELF, MODE_ENG_UNLOCKED, MODE_ENG_LOCKED, MODE_BYPASS
   } mode_type;
endpackage : clock_gen_pkg

// >>> verilog/clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
module clock_gen
   import clock_gen_pkg::*;
#(
   parameter int RTI_CYC         = 25000,
   parameter int EXT_TIMEOUT_CYC = 256
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output var  logic [7:0] regRdata,
   input  wire logic       stopReq,
   input  wire logic       extRefPinIn,
   output var  logic       oscOutPinOut,
   output var  logic       oscOutPinOe,
   output var  logic       mainClockOut,
   output var  logic       loopMultipliedClock,
   output var  logic       extReferenceClock,
   output var  logic       debugLocalClock,
   output var  logic       fixedFreqEnable,
   output var  logic       rtiClockTick,
   output var  logic       highAmplitudeOsc,
   output var  logic       extPinClockIn,
   output var  logic       extPinOscIn,
   output var  logic       lossResetRequest,
   output var  logic       lossInterruptRequest
);
   logic        firstDone_reg, extReserved_reg, hgo_reg, range_reg, ext_reference_select_reg, lossDetDis_reg;
   logic [1:0]  clock_mode_select_reg;
   logic        lolre_reg, locre_reg;
   logic [2:0]  mult_reg, div_reg;
   logic [7:0]  trim_reg;
   logic [15:0] dco_reg, acc_reg, winCnt_reg, extIdle_reg, rtiCnt_reg;
   logic [8:0]  irefCnt_reg;
   logic [1:0]  dbgCnt_reg;
   logic [5:0]  extPre_reg;
   logic [6:0]  divCnt_reg;
   logic [2:0]  lockRun_reg;
   logic        extPrev_reg, extValid_reg, locked_reg, lossLock_reg, lossClock_reg;
   mode_type    mode_reg, mode_next;

   logic        wrCtrl1, wrCtrl2, wrStatus, wrDcoHi, wrDcoLo, wrTrim;
   logic        irefTick, extEdge, extTimeout, extRefTick, refTick, dcoTick, srcTick, divTick;
   logic        engaged, engagedExt, withinTol, outsideTol, lolEvent, locEvent;
   logic [16:0] accSum;
   logic [15:0] target, absDiff;
   logic [8:0]  irefPeriod;
   logic [6:0]  divMask;
   logic [7:0]  statusWord;

   assign wrCtrl1  = regWr && regAddr == ADDR_CTRL1;
   assign wrCtrl2  = regWr && regAddr == ADDR_CTRL2;
   assign wrStatus = regWr && regAddr == ADDR_STATUS;
   assign wrDcoHi  = regWr && regAddr == ADDR_DCO_HI;
   assign wrDcoLo  = regWr && regAddr == ADDR_DCO_LO;
   assign wrTrim   = regWr && regAddr == ADDR_TRIM;

   // The pin role is fixed by the very first write, since the pin cannot be released later.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         firstDone_reg   <= 1'b0;
         extReserved_reg <= 1'b0;
         hgo_reg         <= 1'b0;
         range_reg       <= 1'b0;
         ext_reference_select_reg        <= 1'b0;
         clock_mode_select_reg        <= CLOCK_MODE_SELECT_SELF;
         lossDetDis_reg  <= 1'b0;
      end else if (wrCtrl1) begin
         lossDetDis_reg <= regWdata[C1_LOCD];
         if (!firstDone_reg) begin
            firstDone_reg   <= 1'b1;
            hgo_reg         <= regWdata[C1_HGO];
            range_reg       <= regWdata[C1_RANGE];
            ext_reference_select_reg        <= regWdata[C1_EXT_REFERENCE_SELECT];
            extReserved_reg <= regWdata[C1_CLOCK_MODE_SELECT_HI];
            clock_mode_select_reg        <= regWdata[C1_CLOCK_MODE_SELECT_HI:C1_CLOCK_MODE_SELECT_LO];
         end else if (extReserved_reg || !regWdata[C1_CLOCK_MODE_SELECT_HI]) begin
            clock_mode_select_reg <= regWdata[C1_CLOCK_MODE_SELECT_HI:C1_CLOCK_MODE_SELECT_LO];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lolre_reg <= 1'b0;
         locre_reg <= 1'b0;
         mult_reg  <= 3'h0;
         div_reg   <= 3'h0;
      end else if (wrCtrl2) begin
         lolre_reg <= regWdata[C2_LOLRE];
         locre_reg <= regWdata[C2_LOCRE];
         mult_reg  <= regWdata[C2_MULT_LO +: 3];
         div_reg   <= regWdata[C2_DIV_LO +: 3];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trim_reg <= TRIM_RESET;
      end else if (wrTrim) begin
         trim_reg <= regWdata;
      end
   end

   // Internal reference: the trim moves the period from 32 cycles below nominal to 31 cycles above it.
   assign irefPeriod = 9'(IREF_BASE) + {3'h0, trim_reg[7:2]};
   assign irefTick   = irefCnt_reg >= irefPeriod - 9'h001;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irefCnt_reg <= 9'h000;
      end else if (irefTick) begin
         irefCnt_reg <= 9'h000;
      end else begin
         irefCnt_reg <= irefCnt_reg + 9'h001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dbgCnt_reg      <= 2'h0;
         debugLocalClock <= 1'b0;
      end else if (dbgCnt_reg >= 2'(DEBUG_HALF_CYC - 1)) begin
         dbgCnt_reg      <= 2'h0;
         debugLocalClock <= ~debugLocalClock;
      end else begin
         dbgCnt_reg <= dbgCnt_reg + 2'h1;
      end
   end

   // The interrupt timebase runs from its own counter so mode changes never disturb it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rtiCnt_reg   <= 16'h0000;
         rtiClockTick <= 1'b0;
      end else if (rtiCnt_reg >= 16'(RTI_CYC - 1)) begin
         rtiCnt_reg   <= 16'h0000;
         rtiClockTick <= 1'b1;
      end else begin
         rtiCnt_reg   <= rtiCnt_reg + 16'h0001;
         rtiClockTick <= 1'b0;
      end
   end

   assign extEdge    = extReserved_reg && extRefPinIn && !extPrev_reg;
   assign extTimeout = !extEdge && extIdle_reg >= 16'(EXT_TIMEOUT_CYC - 1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         extPrev_reg  <= 1'b0;
         extIdle_reg  <= 16'h0000;
         extValid_reg <= 1'b0;
      end else begin
         // Track the pin even while unreserved, so a pin already high when reserved is no edge.
         extPrev_reg <= extRefPinIn;
         if (extEdge) begin
            extIdle_reg  <= 16'h0000;
            extValid_reg <= 1'b1;
         end else if (extTimeout) begin
            extValid_reg <= 1'b0;
         end else begin
            extIdle_reg <= extIdle_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         extPre_reg <= 6'h00;
      end else if (extEdge) begin
         extPre_reg <= extRefTick ? 6'h00 : extPre_reg + 6'h01;
      end
   end

   assign extRefTick = extEdge && extPre_reg >= (range_reg ? PRESCALE_HIGH : PRESCALE_LOW);
   assign engaged    = mode_reg == MODE_ENG_UNLOCKED || mode_reg == MODE_ENG_LOCKED;
   assign engagedExt = engaged && clock_mode_select_reg == CLOCK_MODE_SELECT_ENG_EXT;
   assign refTick    = engaged && (engagedExt ? extRefTick : irefTick);

   // Phase accumulator: each carry stands for several oscillator periods of the real loop.
   assign accSum  = {1'b0, acc_reg} + {1'b0, dco_reg};
   assign dcoTick = mode_reg != MODE_OFF && accSum[16];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_reg             <= 16'h0000;
         loopMultipliedClock <= 1'b0;
      end else if (mode_reg != MODE_OFF) begin
         acc_reg <= accSum[15:0];
         if (dcoTick) begin
            loopMultipliedClock <= ~loopMultipliedClock;
         end
      end
   end

   assign target     = 16'(({13'h0000, mult_reg} + 16'h0001) * MULT_UNIT);
   assign absDiff    = winCnt_reg > target ? winCnt_reg - target : target - winCnt_reg;
   assign withinTol  = absDiff <= LOCK_TOL;
   assign outsideTol = absDiff > UNLOCK_TOL;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         winCnt_reg <= 16'h0000;
      end else if (refTick) begin
         winCnt_reg <= {15'h0000, dcoTick};
      end else if (dcoTick) begin
         winCnt_reg <= winCnt_reg + 16'h0001;
      end
   end

   // Without reference ticks nothing moves, so the frequency holds through a lost
   // reference and through stop.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dco_reg <= DCO_RESET;
      end else if (wrDcoHi) begin
         dco_reg <= {regWdata, dco_reg[7:0]};
      end else if (wrDcoLo) begin
         dco_reg <= {dco_reg[15:8], regWdata};
      end else if (refTick && !withinTol) begin
         if (winCnt_reg < target && dco_reg < DCO_MAX) begin
            dco_reg <= dco_reg + 16'h0001;
         end else if (winCnt_reg > target && dco_reg > DCO_MIN) begin
            dco_reg <= dco_reg - 16'h0001;
         end
      end
   end

   assign lolEvent = locked_reg && ((refTick && outsideTol) || (engagedExt && extTimeout));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         locked_reg  <= 1'b0;
         lockRun_reg <= 3'h0;
      end else if (!engaged || lolEvent) begin
         locked_reg  <= 1'b0;
         lockRun_reg <= 3'h0;
      end else if (refTick) begin
         if (!withinTol) begin
            lockRun_reg <= 3'h0;
         end else if (lockRun_reg >= LOCK_WINDOWS - 3'h1) begin
            locked_reg <= 1'b1;
         end else begin
            lockRun_reg <= lockRun_reg + 3'h1;
         end
      end
   end

   // Non-running bypass is refused, as is external-engaged unless already engaged; the current mode stays, but off and bypass fall back to self-clocked.
   always_comb begin
      mode_next = mode_reg;
      if (stopReq) begin
         mode_next = MODE_OFF;
      end else begin
         case (clock_mode_select_reg)
            CLOCK_MODE_SELECT_SELF: begin
               mode_next = MODE_SELF;
            end
            CLOCK_MODE_SELECT_ENG_INT: begin
               mode_next = locked_reg ? MODE_ENG_LOCKED : MODE_ENG_UNLOCKED;
            end
            CLOCK_MODE_SELECT_BYPASS: begin
               if (extValid_reg) begin
                  mode_next = MODE_BYPASS;
               end else if (mode_reg == MODE_OFF || mode_reg == MODE_BYPASS) begin
                  mode_next = MODE_SELF;
               end
            end
            CLOCK_MODE_SELECT_ENG_EXT: begin
               if (extValid_reg || engagedExt) begin
                  mode_next = locked_reg ? MODE_ENG_LOCKED : MODE_ENG_UNLOCKED;
               end else if (mode_reg == MODE_OFF || mode_reg == MODE_BYPASS) begin
                  mode_next = MODE_SELF;
               end
            end
            default: begin
               mode_next = MODE_SELF;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_reg        <= MODE_SELF;
         fixedFreqEnable <= 1'b0;
      end else begin
         mode_reg        <= mode_next;
         fixedFreqEnable <= mode_next == MODE_ENG_LOCKED || mode_next == MODE_BYPASS;
      end
   end

   assign srcTick = mode_reg == MODE_BYPASS ? extEdge : dcoTick;
   assign divMask = 7'((8'h01 << div_reg) - 8'h01);
   assign divTick = mode_reg != MODE_OFF && srcTick && (divCnt_reg & divMask) == divMask;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divCnt_reg   <= 7'h00;
         mainClockOut <= 1'b0;
      end else if (mode_reg != MODE_OFF && srcTick) begin
         divCnt_reg <= divCnt_reg + 7'h01;
         if (divTick) begin
            mainClockOut <= ~mainClockOut;
         end
      end
   end

   assign locEvent = extValid_reg && extTimeout && !lossDetDis_reg && clock_mode_select_reg[1];

   // A new loss arriving with a clear keeps its flag.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lossLock_reg  <= 1'b0;
         lossClock_reg <= 1'b0;
      end else begin
         if (lolEvent) begin
            lossLock_reg <= 1'b1;
         end else if (wrStatus && regWdata[ST_LOSS_LOCK]) begin
            lossLock_reg <= 1'b0;
         end
         if (locEvent) begin
            lossClock_reg <= 1'b1;
         end else if (wrStatus && regWdata[ST_LOSS_CLOCK]) begin
            lossClock_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lossResetRequest     <= 1'b0;
         lossInterruptRequest <= 1'b0;
      end else begin
         lossResetRequest     <= (lossLock_reg && lolre_reg) || (lossClock_reg && locre_reg);
         lossInterruptRequest <= (lossLock_reg && !lolre_reg) || (lossClock_reg && !locre_reg);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         extReferenceClock <= 1'b0;
         extPinClockIn     <= 1'b0;
         extPinOscIn       <= 1'b0;
         oscOutPinOe       <= 1'b0;
         oscOutPinOut      <= 1'b0;
         highAmplitudeOsc  <= 1'b0;
      end else begin
         extReferenceClock <= extReserved_reg && extRefPinIn;
         extPinClockIn     <= extReserved_reg && !ext_reference_select_reg;
         extPinOscIn       <= extReserved_reg && ext_reference_select_reg;
         oscOutPinOe       <= extReserved_reg && ext_reference_select_reg;
         oscOutPinOut      <= extReserved_reg && ext_reference_select_reg && !extRefPinIn;
         highAmplitudeOsc  <= hgo_reg;
      end
   end

   always_comb begin
      statusWord                = 8'h00;
      statusWord[ST_LOSS_CLOCK] = lossClock_reg;
      statusWord[ST_LOCKED]     = locked_reg;
      statusWord[ST_EXT_VALID]  = extValid_reg;
      statusWord[ST_LOSS_LOCK]  = lossLock_reg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ADDR_CTRL1:  regRdata <= {hgo_reg, range_reg, ext_reference_select_reg, clock_mode_select_reg, 1'b0,
                                      lossDetDis_reg, 1'b0};
            ADDR_CTRL2:  regRdata <= {lolre_reg, mult_reg, locre_reg, div_reg};
            ADDR_STATUS: regRdata <= statusWord;
            ADDR_DCO_HI: regRdata <= dco_reg[15:8];
            ADDR_DCO_LO: regRdata <= dco_reg[7:0];
            ADDR_TRIM:   regRdata <= trim_reg;
            default:     regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_lock_lost;
      lolEvent ##1 lossLock_reg;
   endsequence

   a_stop_static: assert property ((mode_reg == MODE_OFF && $past(mode_reg) == MODE_OFF)
      |-> $stable(mainClockOut)) else $error("main clock moved in off mode");
   a_stop_enters_off: assert property (stopReq |=> mode_reg == MODE_OFF)
      else $error("stop did not enter off mode");
   a_lock_engages: assert property ((clock_mode_select_reg == CLOCK_MODE_SELECT_ENG_INT && !stopReq && locked_reg)
      |=> mode_reg == MODE_ENG_LOCKED && fixedFreqEnable) else $error("lock not engaged");
   a_bypass_valid: assert property (mode_reg == MODE_BYPASS |-> $past(extValid_reg))
      else $error("bypass without valid clock");
   a_ext_blocked: assert property ((firstDone_reg && !extReserved_reg) |-> !clock_mode_select_reg[1])
      else $error("external mode after internal first write");
   a_write_once: assert property (firstDone_reg |=> $stable(hgo_reg) && $stable(range_reg)
      && $stable(ext_reference_select_reg)) else $error("write-once bit changed");
   a_hold_lost_ref: assert property ((!refTick && !wrDcoHi && !wrDcoLo) |=> $stable(dco_reg))
      else $error("oscillator setting drifted");
   a_loss_reset: assert property ((lolEvent && lolre_reg) |-> s_lock_lost ##1 lossResetRequest)
      else $error("loss of lock gave no reset request");
   a_div_by_one: assert property ((div_reg == 3'h0 && srcTick && mode_reg != MODE_OFF)
      |=> mainClockOut != $past(mainClockOut)) else $error("divide by one missed");
   a_osc_pin_role: assert property (oscOutPinOe |-> $past(extReserved_reg && ext_reference_select_reg))
      else $error("oscillator pin driven while unreserved");
   a_dco_range: assert property ($changed(dco_reg) && !$past(wrDcoHi) && !$past(wrDcoLo)
      |-> dco_reg >= DCO_MIN && dco_reg <= DCO_MAX) else $error("loop left range");
endmodule : clock_gen
`default_nettype wire

// >>> dv/ext_clock_source.sv
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source #(
   parameter int HALF_CYC = 3
) (
   input  wire logic clk,
   input  wire logic run,
   output var  logic pinLevel
);
   int cnt = 0;
   initial pinLevel = 1'b0;
   // A stopped source freezes at its last level, as a halted oscillator does.
   always @(posedge clk) begin
      if (run) begin
         cnt <= (cnt == HALF_CYC - 1) ? 0 : cnt + 1;
         if (cnt == HALF_CYC - 1) begin
            pinLevel <= ~pinLevel;
         end
      end
   end
endmodule : ext_clock_source
`default_nettype wire

// >>> dv/test_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
module test_clock_gen
   import clock_gen_pkg::*;
;
   logic       clk = 0, rst = 1, regWr = 0, regRd = 0, stopReq = 0, run = 0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWdata = 8'h00, regRdata, got, dcoLo;
   logic       pinLevel, oscOutPinOut, oscOutPinOe, mainClockOut, loopMultipliedClock;
   logic       extReferenceClock, debugLocalClock, fixedFreqEnable, rtiClockTick;
   logic       highAmplitudeOsc, extPinClockIn, extPinOscIn, lossResetRequest;
   logic       lossInterruptRequest;
   logic [31:0] seed = 32'h7a1de13a;
   int         error_cnt = 0, checks = 0, lmT, mcT, tkT, dbT, erT, rfT, d;
   always #20 clk = ~clk;
   ext_clock_source #(.HALF_CYC(2)) i_src (.clk(clk), .run(run), .pinLevel(pinLevel));
   clock_gen #(.RTI_CYC(16), .EXT_TIMEOUT_CYC(16)) i_dut (
      .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .stopReq(stopReq), .extRefPinIn(pinLevel),
      .oscOutPinOut(oscOutPinOut), .oscOutPinOe(oscOutPinOe), .mainClockOut(mainClockOut),
      .loopMultipliedClock(loopMultipliedClock), .extReferenceClock(extReferenceClock),
      .debugLocalClock(debugLocalClock), .fixedFreqEnable(fixedFreqEnable),
      .rtiClockTick(rtiClockTick), .highAmplitudeOsc(highAmplitudeOsc),
      .extPinClockIn(extPinClockIn), .extPinOscIn(extPinOscIn),
      .lossResetRequest(lossResetRequest), .lossInterruptRequest(lossInterruptRequest));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   task finish_test;
      if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk
   task wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task rd(input logic [2:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 got = regRdata;
   endtask : rd
   // Counts edges between settled samples, so the ratio survives any clock phase.
   task measure(input int n);
      logic lm, mc, db, er, rf;
      #1;
      {lmT, mcT, tkT, dbT, erT, rfT} = '0;
      {lm, mc, db, er, rf} = {loopMultipliedClock, mainClockOut, debugLocalClock, pinLevel,
                              extReferenceClock};
      repeat (n) begin
         @(posedge clk);
         #1;
         lmT += int'(loopMultipliedClock !== lm);
         mcT += int'(mainClockOut !== mc);
         dbT += int'(debugLocalClock !== db);
         erT += int'(pinLevel && !er);
         tkT += int'(rtiClockTick === 1'b1);
         rfT += int'(extReferenceClock && !rf);
         {lm, mc, db, er, rf} = {loopMultipliedClock, mainClockOut, debugLocalClock, pinLevel,
                                 extReferenceClock};
      end
   endtask : measure
   task wait_status(input int b, input logic v);
      for (int i = 0; i < 4000; i++) begin
         rd(ADDR_STATUS);
         if (got[b] === v) break;
      end
      chk("status bit", v, got[b]);
   endtask : wait_status
   function automatic logic near(input int a, input int b);
      return (a - b >= -1) && (a - b <= 1);
   endfunction : near
   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_DCO_HI); chk("dco hi", 8'h20, got);
      rd(ADDR_TRIM); chk("trim", 8'h80, got);
      rd(ADDR_STATUS); chk("status", 8'h00, got);
      wr(ADDR_TRIM, 8'h00);
      wr(ADDR_CTRL2, 8'h10);
      wr(ADDR_CTRL1, 8'h88);
      wr(ADDR_CTRL1, 8'h10);
      rd(ADDR_CTRL1); chk("ctrl1", 5'h11, got[7:3]);
      chk("high gain", 1, highAmplitudeOsc);
      chk("pin roles", 0, {oscOutPinOe, extPinClockIn, extPinOscIn});
      wait_status(ST_LOCKED, 1'b1);
      chk("fixed enable", 1, fixedFreqEnable);
      for (d = 0; d < 8; d++) begin
         wr(ADDR_CTRL2, 8'h10 | 8'(d));
         measure(4096);
         chk("divided clock", 1, near(mcT, lmT >> d));
         chk("rti ticks", 256, tkT);
         chk("debug clock", 4096, dbT);
      end
      stopReq <= 1'b1;
      rd(ADDR_DCO_LO);
      dcoLo = got;
      measure(64);
      chk("stopped clocks", 0, mcT + lmT);
      stopReq <= 1'b0;
      rd(ADDR_DCO_LO); chk("dco kept", dcoLo, got);
      wr(ADDR_CTRL2, 8'h90);
      wait_status(ST_LOCKED, 1'b1);
      wr(ADDR_TRIM, 8'hfc);
      wait_status(ST_LOSS_LOCK, 1'b1);
      chk("lock reset request", 1, lossResetRequest);
      repeat (4) begin
         seed = xorshift(seed);
         wr(ADDR_TRIM, seed[7:0]);
         wr({2'b11, seed[8]}, seed[15:8]);
         rd(ADDR_TRIM); chk("trim", seed[7:0], got);
         rd({2'b11, seed[8]}); chk("unmapped", 0, got);
      end
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      run <= 1'b1;
      wr(ADDR_CTRL2, 8'h70);
      wr(ADDR_CTRL1, 8'h18);
      @(posedge clk);
      #1 chk("pin roles", 3'b010, {oscOutPinOe, extPinClockIn, extPinOscIn});
      wait_status(ST_EXT_VALID, 1'b1);
      wait_status(ST_LOCKED, 1'b1);
      wr(ADDR_CTRL1, 8'h50);
      @(posedge clk);
      measure(600);
      chk("bypass clock", 1, near(mcT, erT));
      chk("ext ref clock", 1, near(rfT, erT));
      run <= 1'b0;
      wr(ADDR_CTRL2, 8'h08);
      measure(64);
      chk("dco after loss", 1, lmT > 0);
      chk("fallback clock", 1, mcT > 0);
      rd(ADDR_STATUS); chk("ext valid", 0, got[ST_EXT_VALID]);
      chk("clock lost", 1, got[ST_LOSS_CLOCK]);
      chk("reset request", 1, lossResetRequest);
      wr(ADDR_CTRL2, 8'h00);
      @(posedge clk);
      #1 chk("interrupt request", 1, lossInterruptRequest);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      wr(ADDR_CTRL1, 8'h30);
      @(posedge clk);
      #1 chk("crystal roles", 3'b101, {oscOutPinOe, extPinClockIn, extPinOscIn});
      chk("osc drive", !pinLevel, oscOutPinOut);
      chk("low gain", 0, highAmplitudeOsc);
      finish_test();
   end
endmodule : test_clock_gen
`default_nettype wire
